/* bench/load_adaptive_diag_tb.sv */
// Self-checking bench of the diagnostic outputs and load-adaptive commutation
module load_adaptive_diag_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import diag_commutation_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, r;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic por, ovl, blk, sreq, ca, cb, d0o, d0e, d1o, d1e, l0, l1, fs, stp, sp, cp, pcmp, prch, prev;
  logic [8:0] load;
  logic [9:0] ms;
  logic [22:0] vel;
  int errors, comparisons, cyc;
  // Rows: microstep count, expected sine and cosine polarity
  logic [11:0] rows [8] = '{{10'd0, 2'b11}, {10'd255, 2'b11}, {10'd256, 2'b01}, {10'd511, 2'b01},
                            {10'd512, 2'b00}, {10'd767, 2'b00}, {10'd768, 2'b10}, {10'd1023, 2'b10}};

  load_adaptive_diag u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .por_active(por), .overload(ovl),
    .blocked(blk), .load_meas(load), .microstep_counter(ms), .chop_on_a(ca), .chop_on_b(cb),
    .step_request(sreq), .pos_compare(pcmp), .pos_reached(prch), .diag_out_first_o(d0o),
    .diag_out_first_oe(d0e), .diag_out_second_o(d1o), .diag_out_second_oe(d1e), .actual_velocity(vel),
    .fullstep_q(fs), .step_out_q(stp), .wave_sine_pos_q(sp), .wave_cosine_pos_q(cp));

  motor_side_model u_motor (.aclk(aclk), .p0_o(d0o), .p0_oe(d0e), .p1_o(d1o), .p1_oe(d1e),
    .step_req(sreq), .chop_a(ca), .chop_b(cb), .lvl0(l0), .lvl1(l1));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = !aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit ka, kw, da, dw, kb;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ka = awready && !da;
      kw = wready && !dw;
      @(posedge aclk);
      if (ka) begin awvalid <= 1'b0; da = 1; end
      if (kw) begin wvalid <= 1'b0; dw = 1; end
    end
    while (!kb)
    begin
      @(negedge aclk);
      kb = bvalid;
      resp = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit ka, kr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!kr)
    begin
      @(negedge aclk);
      ka = arready;
      kr = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ka) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf; por = 1'b0; ovl = 1'b0; blk = 1'b0;
    load = 9'h000; ms = 10'h005; pcmp = 1'b0; prch = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wt(2); chk({31'h0, l0}, 32'h0);
    rd(ADDR_RAMP_STAT, r, rsp); chk(r & 32'h14, 32'h14);
    rd(ADDR_RAMP_STAT, r, rsp); chk(r & 32'h10, 32'h0);
    wt(1); chk({31'h0, l0}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge aclk);
      ms <= rows[i][11:2];
      wt(3); chk({30'h0, sp, cp}, {30'h0, rows[i][1:0]});
    end
    wr(ADDR_DIAG_CONF, 32'h189, rsp);
    rd(ADDR_DIAG_CONF, r, rsp); chk(r, 32'h189);
    @(posedge aclk); ms <= 10'h000;
    wt(3); chk({29'h0, l0, d0e, l1}, 32'h3);
    @(posedge aclk); ms <= 10'h005;
    wt(3); chk({29'h0, l0, d0e, l1}, 32'h4);
    @(posedge aclk); por <= 1'b1;
    wt(3); chk({30'h0, d0o, d0e}, 32'h1);
    @(posedge aclk); por <= 1'b0;
    wr(ADDR_DIAG_CONF, 32'h198, rsp);
    wr(ADDR_MIN_VEL, 32'd10, rsp);
    wr(ADDR_TARGET_VEL, 32'd20, rsp);
    wr(ADDR_LOAD_THR, 32'd12, rsp);
    wr(ADDR_COMM_CONF, 32'h032000c8, rsp);
    wt(40); chk({8'h0, fs, vel}, {8'h0, 1'b1, 23'd20});
    @(posedge aclk); ovl <= 1'b1;
    wt(40); chk({9'h0, vel}, 32'd10);
    prev = d1o;
    wt(8); chk({31'h0, d1o}, {31'h0, !prev});
    @(posedge aclk); ovl <= 1'b0;
    wt(40); chk({9'h0, vel}, 32'd20);
    wr(ADDR_COMM_CONF, 32'h032002cf, rsp);
    @(posedge aclk); blk <= 1'b1;
    wt(40); chk({8'h0, l0, vel}, 32'd0);
    @(posedge aclk); blk <= 1'b0;
    wt(40); chk({9'h0, vel}, 32'd0);
    rd(ADDR_RAMP_STAT, r, rsp); chk(r & 32'h3, 32'h3);
    wt(40); chk({8'h0, l0, vel}, {8'h0, 1'b1, 23'd20});
    wr(ADDR_COMM_CONF, 32'h032001c8, rsp);
    wt(5); chk({31'h0, fs}, 32'h0);
    wr(ADDR_COMM_CONF, 32'h032000c8, rsp);
    wr(ADDR_MIN_VEL, 32'h7fffff, rsp);
    rd(ADDR_MIN_VEL, r, rsp); chk(r, 32'h400000);
    wr(ADDR_MIN_VEL, 32'd10, rsp);
    wt(5); chk({31'h0, fs}, 32'h1);
    wr(ADDR_MIN_VEL, 32'h0, rsp);
    wt(5); chk({31'h0, fs}, 32'h0);
    wr(ADDR_TARGET_VEL, 32'h400000, rsp);
    wt(5); prev = stp;
    wt(1); chk({30'h0, fs, prev ^ stp}, 32'h1);
    @(posedge aclk); load <= 9'h1a5;
    rd(ADDR_LOAD_VAL, r, rsp); chk(r, 32'h1a5);
    wr(ADDR_DIAG_CONF, 32'h0ec, rsp);
    @(posedge aclk); pcmp <= 1'b1;
    wt(3); chk({30'h0, d0o, d1o}, 32'h2);
    @(posedge aclk); prch <= 1'b1;
    @(posedge aclk); prch <= 1'b0;
    wt(3); chk({30'h0, d0o, d1o}, 32'h3);
    rd(ADDR_RAMP_STAT, r, rsp); chk(r & 32'h4, 32'h4);
    wt(3); chk({30'h0, d0o, d1o}, 32'h2);
    @(posedge aclk); pcmp <= 1'b0; aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wt(2); chk({31'h0, l0}, 32'h0);
    rd(ADDR_DIAG_CONF, r, rsp); chk(r, 32'h0);
    rd(8'h20, r, rsp); chk({r[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(8'h24, 32'h1, rsp); chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    test_done();
  end
endmodule

/* bench/motor_side_model.sv */
// Motor-side model: step requests, chopper phases and pull-ups on the diagnostic lines
module motor_side_model
  import diag_commutation_pkg::*;
(
  // Clock
  input  wire logic aclk,
  // Pins from the block
  input  wire logic p0_o,
  input  wire logic p0_oe,
  input  wire logic p1_o,
  input  wire logic p1_oe,
  // Status into the block
  output logic      step_req,
  output logic      chop_a,
  output logic      chop_b,
  // Resolved pin levels
  output logic      lvl0,
  output logic      lvl1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  always_ff @(posedge aclk)
  begin
    cnt_q <= cnt_q + 4'h1;
  end
  // One requested step every eight cycles, coils chopping in turn
  assign step_req = (cnt_q[2:0] == 3'h7);
  assign chop_a   = cnt_q[3];
  assign chop_b   = !cnt_q[3];
  // External pull-ups: a released line reads high
  assign lvl0 = p0_oe ? p0_o : 1'b1;
  assign lvl1 = p1_oe ? p1_o : 1'b1;
endmodule

/* hw/commutation_seq.sv */
// Load-adaptive fullstep commutation sequencer with velocity limiting
module commutation_seq
  import diag_commutation_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Configuration
  input  wire logic [VEL_W-1:0]      target_vel,
  input  wire logic [VEL_W-1:0]      min_vel,
  input  wire logic                  enable,
  input  wire logic                  stopped,
  // Motor feedback
  input  wire logic                  overload,
  input  wire logic                  blocked,
  // Outputs
  output logic [VEL_W-1:0]           vel_q,
  output logic                       step_q
);
  logic [VEL_W:0] acc_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || stopped)
      vel_q <= '0;
    else if (!enable)
      vel_q <= target_vel;
    else if (overload || blocked)
      vel_q <= (vel_q > min_vel) ? vel_q - 1'b1 : min_vel;
    else if (vel_q < target_vel)
      vel_q <= vel_q + 1'b1;
    else
      vel_q <= target_vel;
  end
  // Phase accumulator making one step per wrap
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_q  <= '0;
      step_q <= 1'b0;
    end
    else
    begin
      acc_q  <= {1'b0, acc_q[VEL_W-1:0]} + {1'b0, vel_q};
      step_q <= acc_q[VEL_W];
    end
  end
endmodule

/* hw/diag_pin_driver.sv */
// One diagnostic output pin with source select and driver type
module diag_pin_driver
  import diag_commutation_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Configuration
  input  wire logic [SEL_W-1:0]      sel,
  input  wire logic                  push_pull,
  input  wire logic                  force_low,
  // Sources
  input  wire logic [7:0]            src,
  // Pin
  output logic                       pin_o,
  output logic                       pin_oe
);
  logic active;
  assign active = src[sel];
  always_ff @(posedge aclk)
  begin
    if (!aresetn || force_low)
    begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b1;
    end
    else if (push_pull)
    begin
      pin_o  <= active;
      pin_oe <= 1'b1;
    end
    else
    begin
      pin_o  <= 1'b0;
      pin_oe <= active;
    end
  end
endmodule

/* hw/load_adaptive_diag.sv */
// Top: diagnostic outputs and load-adaptive commutation with AXI4-Lite registers
module load_adaptive_diag
  import diag_commutation_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Motor and core status
  input  wire logic                  por_active,
  input  wire logic                  overload,
  input  wire logic                  blocked,
  input  wire logic [LOAD_W-1:0]     load_meas,
  input  wire logic [MS_W-1:0]       microstep_counter,
  input  wire logic                  chop_on_a,
  input  wire logic                  chop_on_b,
  input  wire logic                  step_request,
  input  wire logic                  pos_compare,
  input  wire logic                  pos_reached,
  // Diagnostic pins
  output logic                       diag_out_first_o,
  output logic                       diag_out_first_oe,
  output logic                       diag_out_second_o,
  output logic                       diag_out_second_oe,
  // Commutation outputs
  output logic [VEL_W-1:0]           actual_velocity,
  output logic                       fullstep_q,
  output logic                       step_out_q,
  output logic                       wave_sine_pos_q,
  output logic                       wave_cosine_pos_q
);
  import diag_commutation_pkg::*;

  logic [31:0]       diag_conf_q;
  logic [31:0]       comm_conf_q;
  logic [VEL_W-1:0]  commutation_min_velocity;
  logic [VEL_W-1:0]  target_vel_q;
  logic [VEL_W-1:0]  load_detect_velocity_threshold;
  logic              stall_q;
  logic              stall_stop_event;
  logic              pos_evt_q;
  logic              reset_flag_q;
  logic              skip_tgl_q;
  logic              stat_read;
  logic [31:0]       rdata_d;
  logic [VEL_W-1:0]  vel;
  logic              step_int;
  logic              comm_active;
  logic [3:0]        chopper_off_time;
  logic              chop_phase_q;
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              do_write;
  logic [7:0]        src0;
  logic [7:0]        src1;
  logic              step_dir_select;

  // Write channel capture, either order
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q[7:2] <= ADDR_LOAD_THR[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Writable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      diag_conf_q                    <= '0;
      comm_conf_q                    <= '0;
      commutation_min_velocity       <= '0;
      target_vel_q                   <= '0;
      load_detect_velocity_threshold <= '0;
    end
    else if (do_write)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wstrb_q[b])
        begin
          unique case (awaddr_q)
            ADDR_DIAG_CONF: diag_conf_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            ADDR_COMM_CONF: comm_conf_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            default: ;
          endcase
        end
      end
      if (awaddr_q == ADDR_MIN_VEL)
        commutation_min_velocity <= (wdata_q[VEL_W-1:0] > MIN_VEL_MAX) ? MIN_VEL_MAX
                                                                          : wdata_q[VEL_W-1:0];
      if (awaddr_q == ADDR_TARGET_VEL)
        target_vel_q <= wdata_q[VEL_W-1:0];
      if (awaddr_q == ADDR_LOAD_THR)
        load_detect_velocity_threshold <= wdata_q[VEL_W-1:0];
    end
  end

  // Read channel
  assign stat_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_RAMP_STAT);
  always_comb
  begin
    rdata_d = '0;
    unique case (s_axi_araddr)
      ADDR_DIAG_CONF:  rdata_d = diag_conf_q;
      ADDR_COMM_CONF:  rdata_d = comm_conf_q;
      ADDR_MIN_VEL:    rdata_d[VEL_W-1:0] = commutation_min_velocity;
      ADDR_TARGET_VEL: rdata_d[VEL_W-1:0] = target_vel_q;
      ADDR_LOAD_THR:   rdata_d[VEL_W-1:0] = load_detect_velocity_threshold;
      ADDR_RAMP_STAT:
      begin
        rdata_d[F_STALL]      = stall_q;
        rdata_d[F_STOP_EVT]   = stall_stop_event;
        rdata_d[F_POS_EVT]    = pos_evt_q;
        rdata_d[F_ACTIVE]     = comm_active;
        rdata_d[F_RESET_FLAG] = reset_flag_q;
      end
      ADDR_ACT_VEL:    rdata_d[VEL_W-1:0] = vel;
      ADDR_LOAD_VAL:   rdata_d[LOAD_W-1:0] = load_meas;
      default:         rdata_d = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_d;
        s_axi_rresp  <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= ADDR_LOAD_VAL) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Commutation enable and mode
  assign chopper_off_time = (comm_conf_q[F_CHOPPER_OFF_TIME +: 4] > CHOPPER_OFF_TIME_CLAMP) ? CHOPPER_OFF_TIME_CLAMP
                                                                   : comm_conf_q[F_CHOPPER_OFF_TIME +: 4];
  assign comm_active = (commutation_min_velocity != '0) && !comm_conf_q[F_QUIET]
                       && comm_conf_q[F_HIGHFS] && comm_conf_q[F_HIGHCHM]
                       && (target_vel_q > commutation_min_velocity);

  commutation_seq u_seq
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .target_vel (target_vel_q),
    .min_vel    (commutation_min_velocity),
    .enable     (comm_active),
    .stopped    (stall_stop_event),
    .overload   (overload),
    .blocked    (blocked),
    .vel_q      (vel),
    .step_q     (step_int)
  );

  // Status flags, set wins over read-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stall_q          <= 1'b0;
      stall_stop_event <= 1'b0;
      pos_evt_q        <= 1'b1;
      reset_flag_q     <= 1'b1;
    end
    else
    begin
      stall_q          <= (comm_active && blocked) || (stall_q && !stat_read);
      stall_stop_event <= (comm_active && blocked && comm_conf_q[F_STOP_STALL])
                          || (stall_stop_event && !stat_read);
      pos_evt_q        <= pos_reached || (pos_evt_q && !stat_read);
      reset_flag_q     <= reset_flag_q && !stat_read;
    end
  end

  // Skipped-step toggle and chopper phase alternation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      skip_tgl_q   <= 1'b0;
      chop_phase_q <= 1'b0;
    end
    else
    begin
      if (comm_active && step_request && !step_int)
        skip_tgl_q <= !skip_tgl_q;
      if (chopper_off_time != '0 && !comm_conf_q[F_QUIET])
        chop_phase_q <= !chop_phase_q;
    end
  end

  // Diagnostic sources
  assign step_dir_select = diag_conf_q[F_STEP_DIR_SELECT];
  always_comb
  begin
    src0 = '0;
    src1 = '0;
    if (step_dir_select)
    begin
      src0[SRC_STALL]   = stall_q;
      src0[SRC_INDEX]   = (microstep_counter == MS_ZERO);
      src0[SRC_CHOP_ON] = chop_phase_q ? chop_on_b : chop_on_a;
      src0[SRC_SKIP]    = skip_tgl_q;
    end
    else
    begin
      src0[SRC_STALL]    = pos_evt_q || stall_stop_event;
      src0[SRC_POS_CMP]  = pos_compare;
      src0[SRC_RAMP_IRQ] = pos_evt_q || stall_stop_event;
    end
    src1 = src0;
  end

  diag_pin_driver u_diag0
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .sel       (diag_conf_q[F_SEL0 +: SEL_W]),
    .push_pull (diag_conf_q[F_PP0]),
    .force_low (por_active),
    .src       (src0),
    .pin_o     (diag_out_first_o),
    .pin_oe    (diag_out_first_oe)
  );

  diag_pin_driver u_diag_out_second
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .sel       (diag_conf_q[F_SEL1 +: SEL_W]),
    .push_pull (diag_conf_q[F_PP1]),
    .force_low (1'b0),
    .src       (src1),
    .pin_o     (diag_out_second_o),
    .pin_oe    (diag_out_second_oe)
  );

  // Registered commutation outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      actual_velocity   <= '0;
      fullstep_q        <= 1'b0;
      step_out_q        <= 1'b0;
      wave_sine_pos_q   <= 1'b0;
      wave_cosine_pos_q <= 1'b0;
    end
    else
    begin
      actual_velocity   <= vel;
      fullstep_q        <= comm_active;
      step_out_q        <= step_int;
      wave_sine_pos_q   <= sine_positive(microstep_counter);
      wave_cosine_pos_q <= cosine_positive(microstep_counter);
    end
  end

  // Assertions
  property p_por_low;
    @(posedge aclk) disable iff (!aresetn) por_active |=> (!diag_out_first_o && diag_out_first_oe);
  endproperty
  a_por_low: assert property (p_por_low) else $error("first output not low in reset");
  property p_od_release;
    @(posedge aclk) disable iff (!aresetn) (!por_active && !diag_conf_q[F_PP0]) |=> !diag_out_first_o;
  endproperty
  a_od_release: assert property (p_od_release) else $error("open drain drove high");
  property p_stop_zero;
    @(posedge aclk) disable iff (!aresetn) stall_stop_event |=> (vel == '0);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("velocity not zero after stall stop");
  property p_stall_set;
    @(posedge aclk) disable iff (!aresetn) (comm_active && blocked) |=> stall_q;
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall flag not set");
  property p_min_vel;
    @(posedge aclk) disable iff (!aresetn) (comm_active && !stall_stop_event && $past(comm_active)
      && $past(vel) >= commutation_min_velocity) |-> (vel >= commutation_min_velocity || vel == target_vel_q);
  endproperty
  a_min_vel: assert property (p_min_vel) else $error("velocity below minimum");
  property p_quiet_off;
    @(posedge aclk) disable iff (!aresetn) comm_conf_q[F_QUIET] |=> !fullstep_q;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("commutation active in quiet mode");
  property p_skip;
    @(posedge aclk) disable iff (!aresetn) (comm_active && step_request && !step_int)
      |=> (skip_tgl_q != $past(skip_tgl_q));
  endproperty
  a_skip: assert property (p_skip) else $error("skip toggle missing");
  property p_sine;
    @(posedge aclk) disable iff (!aresetn) (microstep_counter == 10'd256) |=> !wave_sine_pos_q;
  endproperty
  a_sine: assert property (p_sine) else $error("sine polarity wrong");
  property p_chopper_off_time_clamp;
    @(posedge aclk) disable iff (!aresetn) (comm_conf_q[F_CHOPPER_OFF_TIME +: 4] >= CHOPPER_OFF_TIME_CLAMP)
      |-> (chopper_off_time == CHOPPER_OFF_TIME_CLAMP);
  endproperty
  a_chopper_off_time_clamp: assert property (p_chopper_off_time_clamp) else $error("off time not clamped");
  c_stall: cover property (@(posedge aclk) disable iff (!aresetn) stall_stop_event);
  c_full: cover property (@(posedge aclk) disable iff (!aresetn) fullstep_q);
  c_skip: cover property (@(posedge aclk) disable iff (!aresetn) $changed(skip_tgl_q));
endmodule

/* inc/diag_commutation_pkg.sv */
// Package with register map, fields and constants of the diagnostic and load-adaptive commutation block
package diag_commutation_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_DIAG_CONF  = 8'h00;
  localparam logic [7:0] ADDR_COMM_CONF  = 8'h04;
  localparam logic [7:0] ADDR_MIN_VEL    = 8'h08;
  localparam logic [7:0] ADDR_TARGET_VEL = 8'h0c;
  localparam logic [7:0] ADDR_LOAD_THR   = 8'h10;
  localparam logic [7:0] ADDR_RAMP_STAT  = 8'h14;
  localparam logic [7:0] ADDR_ACT_VEL    = 8'h18;
  localparam logic [7:0] ADDR_LOAD_VAL   = 8'h1c;
  // Widths
  localparam int VEL_W  = 23;
  localparam int MS_W   = 10;
  localparam int LOAD_W = 9;
  // Diagnostic configuration fields
  localparam int SEL_W        = 3;
  localparam int F_SEL0       = 0;
  localparam int F_SEL1       = 3;
  localparam int F_PP0        = 6;
  localparam int F_PP1        = 7;
  localparam int F_STEP_DIR_SELECT    = 8;
  // Commutation configuration fields
  localparam int F_CHOPPER_OFF_TIME       = 0;
  localparam int F_TBL        = 4;
  localparam int F_HIGHFS     = 6;
  localparam int F_HIGHCHM    = 7;
  localparam int F_QUIET      = 8;
  localparam int F_STOP_STALL = 9;
  localparam int F_PWIDTH     = 16;
  localparam int F_SENS       = 24;
  // Status fields
  localparam int F_STALL      = 0;
  localparam int F_STOP_EVT   = 1;
  localparam int F_POS_EVT    = 2;
  localparam int F_ACTIVE     = 3;
  localparam int F_RESET_FLAG = 4;
  // Off-time clamp and limits
  localparam logic [3:0]        CHOPPER_OFF_TIME_CLAMP = 4'h8;
  localparam logic [VEL_W-1:0]  MIN_VEL_MAX = 23'h400000;
  localparam logic [LOAD_W-1:0] LOAD_NORM_MAX = 9'h0ff;
  localparam logic [MS_W-1:0]   MS_ZERO = 10'h000;
  localparam logic [7:0]        FS_STEP = 8'hff;
  localparam logic [1:0]        RESP_OKAY = 2'b00;
  localparam logic [1:0]        RESP_SLVERR = 2'b10;
  // Diagnostic source selection
  typedef enum logic [2:0]
  {
    SRC_STALL   = 3'b000,
    SRC_INDEX   = 3'b001,
    SRC_CHOP_ON = 3'b010,
    SRC_SKIP    = 3'b011,
    SRC_POS_CMP = 3'b100,
    SRC_RAMP_IRQ= 3'b101
  } diag_src_e;
  // Mode of the commutation sequencer
  typedef enum logic [1:0]
  {
    MODE_MICRO   = 2'b00,
    MODE_FULL    = 2'b01,
    MODE_STOPPED = 2'b10
  } comm_mode_e;
  // Positive sine polarity region of the wave table
  function automatic logic sine_positive(input logic [MS_W-1:0] cnt);
    return (cnt >= 10'd768) || (cnt <= 10'd255);
  endfunction
  // Positive cosine polarity region of the wave table
  function automatic logic cosine_positive(input logic [MS_W-1:0] cnt);
    return cnt <= 10'd511;
  endfunction
endpackage
